// [core/gcct_pkg.sv]
/*
 * Package for the four channel capture/compare timer: widths, modes, encodings.
 * Assumes a single 100 MHz clock domain and no register bus.
 */
package gcct_pkg;
	// ==========================================================
	// Sizes
	localparam int GCCT_CNT_W = 16;
	localparam int GCCT_NCH = 4;
	localparam int GCCT_PRE_W = 3;
	localparam int GCCT_PRE_STAGES = 7;
	localparam int GCCT_ACC_CH = 3;
	// ==========================================================
	// Edge select codes
	localparam logic [1:0] GCCT_EDGE_OFF = 2'h0;
	localparam logic [1:0] GCCT_EDGE_RISE = 2'h1;
	localparam logic [1:0] GCCT_EDGE_FALL = 2'h2;
	localparam logic [1:0] GCCT_EDGE_BOTH = 2'h3;
	// ==========================================================
	// Compare output action codes
	localparam logic [1:0] GCCT_ACT_NONE = 2'h0;
	localparam logic [1:0] GCCT_ACT_TOGGLE = 2'h1;
	localparam logic [1:0] GCCT_ACT_CLEAR = 2'h2;
	localparam logic [1:0] GCCT_ACT_SET = 2'h3;
	// ==========================================================
	// Reset values
	localparam logic [15:0] GCCT_CNT_RST = 16'h0000;
	localparam logic [GCCT_PRE_STAGES-1:0] GCCT_PRE_RST = 7'h00;
endpackage

// [core/gcct_timer.sv]
/*
 * Four channel capture/compare timer with shared 16-bit counter, prescaler,
 * overflow flag and a pulse accumulator on channel three.
 * Assumes capture pins are asynchronous; control bits come from the same clock.
 */
// How it works
// R1: One shared 16-bit counter advanced through a seven-stage prescaler.
// R2: Four channels, each independently set for capture or compare.
// R3: Channel three may instead serve as the pulse accumulator.
// R4: Each counter wrap past 16 bits raises the overflow flag.
// R5: Capture latches the counter on the chosen input edge.
// R6: Compare match drives the output action and raises a flag.
// R7: Capture and compare channels run at once off one counter.
// R8: Accumulator counts edges or counts ticks while its input is active.
// R9: Prescale divides the clock by 1 to 128 in powers of two.
// R10: Channel and overflow events set sticky flags; software clears them; enables gate irq.
`timescale 1ns/1ps
module gcct_timer
	import gcct_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic timer_en,
	input wire logic [GCCT_PRE_W-1:0] prescale_sel,
	input wire logic [GCCT_NCH-1:0] chan_is_compare,
	input wire logic [2*GCCT_NCH-1:0] capture_edge,
	input wire logic [2*GCCT_NCH-1:0] compare_action,
	input wire logic [GCCT_CNT_W*GCCT_NCH-1:0] compare_value,
	input wire logic acc_enable,
	input wire logic acc_gated,
	input wire logic acc_active_high,
	input wire logic [GCCT_NCH-1:0] chan_in,
	input wire logic [GCCT_NCH+1:0] flag_clear,
	input wire logic [GCCT_NCH+1:0] flag_enable,
	output logic [GCCT_CNT_W-1:0] count,
	output logic [GCCT_CNT_W*GCCT_NCH-1:0] capture_value,
	output logic [GCCT_CNT_W-1:0] acc_count,
	output logic [GCCT_NCH-1:0] chan_out,
	output logic [GCCT_NCH+1:0] flags,
	output logic irq
);
	// ==========================================================
	// Prescaler and counter
	logic [GCCT_PRE_STAGES-1:0] pre_r;
	logic [GCCT_PRE_STAGES:0] pre_ext;
	logic tick;
	logic [GCCT_CNT_W-1:0] count_r;
	logic ovf_evt;

	// R9 power of two divide
	assign pre_ext = {pre_r, 1'b0} | {{GCCT_PRE_STAGES{1'b0}}, 1'b1};
	assign tick = timer_en & ((prescale_sel == 3'h0) ? 1'b1 :
		(&pre_ext[prescale_sel -: 1] & ((pre_r & ((7'h01 << prescale_sel) - 7'h01)) ==
		((7'h01 << prescale_sel) - 7'h01))));
	assign ovf_evt = tick & (count_r == 16'hFFFF);
	assign count = count_r;

	// R1 prescaler and counter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_r <= GCCT_PRE_RST;
			count_r <= GCCT_CNT_RST;
		end else begin
			if (timer_en) begin
				pre_r <= pre_r + 7'h01;
			end
			if (tick) begin
				count_r <= count_r + 16'h0001;
			end
		end
	end

	// ==========================================================
	// Input synchronisers
	logic [GCCT_NCH-1:0] sync1_r;
	logic [GCCT_NCH-1:0] sync2_r;
	logic [GCCT_NCH-1:0] prev_r;
	logic [GCCT_NCH-1:0] rise;
	logic [GCCT_NCH-1:0] fall;

	// Two-stage synchroniser then an edge history stage
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
		end else begin
			sync1_r <= chan_in;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end
	assign rise = sync2_r & ~prev_r;
	assign fall = ~sync2_r & prev_r;

	// ==========================================================
	// Channels
	logic [GCCT_NCH-1:0] cap_evt;
	logic [GCCT_NCH-1:0] cmp_evt;
	logic [GCCT_NCH-1:0] acc_mode;
	logic [GCCT_NCH-1:0] ch_evt;

	genvar gi;
	generate
		for (gi = 0; gi < GCCT_NCH; gi++) begin : g_ch
			logic [1:0] edge_sel;
			logic [1:0] act;
			logic edge_hit;
			logic [GCCT_CNT_W-1:0] cap_r;
			logic out_r;
			assign edge_sel = capture_edge[2*gi +: 2];
			assign act = compare_action[2*gi +: 2];
			// R3 channel three taken by accumulator
			assign acc_mode[gi] = (gi == GCCT_ACC_CH) && acc_enable;
			assign edge_hit = ((edge_sel == GCCT_EDGE_RISE) & rise[gi]) |
				((edge_sel == GCCT_EDGE_FALL) & fall[gi]) |
				((edge_sel == GCCT_EDGE_BOTH) & (rise[gi] | fall[gi]));
			// R2 R7 per channel mode select
			assign cap_evt[gi] = ~acc_mode[gi] & ~chan_is_compare[gi] & edge_hit;
			// R6 compare match on counter tick
			assign cmp_evt[gi] = ~acc_mode[gi] & chan_is_compare[gi] & tick &
				(count_r == compare_value[GCCT_CNT_W*gi +: GCCT_CNT_W]);
			assign ch_evt[gi] = cap_evt[gi] | cmp_evt[gi];
			assign capture_value[GCCT_CNT_W*gi +: GCCT_CNT_W] = cap_r;
			assign chan_out[gi] = out_r;
			// R5 capture latch and R6 output action
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					cap_r <= GCCT_CNT_RST;
					out_r <= 1'b0;
				end else begin
					if (cap_evt[gi]) begin
						cap_r <= count_r;
					end
					if (cmp_evt[gi]) begin
						unique case (act)
							GCCT_ACT_NONE: out_r <= out_r;
							GCCT_ACT_TOGGLE: out_r <= ~out_r;
							GCCT_ACT_CLEAR: out_r <= 1'b0;
							GCCT_ACT_SET: out_r <= 1'b1;
						endcase
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Pulse accumulator
	logic [GCCT_CNT_W-1:0] acc_r;
	logic acc_inc;
	logic acc_ovf;
	logic acc_level;

	assign acc_level = ~(sync2_r[GCCT_ACC_CH] ^ acc_active_high);
	// R8 event or gated time counting
	assign acc_inc = acc_enable & (acc_gated ? (tick & acc_level) :
		(acc_active_high ? rise[GCCT_ACC_CH] : fall[GCCT_ACC_CH]));
	assign acc_ovf = acc_inc & (acc_r == 16'hFFFF);
	assign acc_count = acc_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_r <= GCCT_CNT_RST;
		end else if (acc_inc) begin
			acc_r <= acc_r + 16'h0001;
		end
	end

	// ==========================================================
	// Sticky flags: channels, counter overflow, accumulator overflow
	logic [GCCT_NCH+1:0] flag_r;
	logic [GCCT_NCH+1:0] flag_set;

	// R4 overflow event folded into flags
	assign flag_set = {acc_ovf, ovf_evt, ch_evt};
	assign flags = flag_r;
	assign irq = |(flag_r & flag_enable);

	// R10 set wins over clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flag_r <= '0;
		end else begin
			flag_r <= (flag_r & ~flag_clear) | flag_set;
		end
	end

	// ==========================================================
	// Assertions
	property p_count_step; // R1
		@(posedge clk) disable iff (!reset_n)
		tick |=> count_r == $past(count_r) + 16'h0001;
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter did not step on tick");

	property p_div1; // R9
		@(posedge clk) disable iff (!reset_n)
		(timer_en && prescale_sel == 3'h0) |-> tick;
	endproperty
	a_div1: assert property (p_div1) else $error("divide by one missed tick");

	property p_div2; // R9
		@(posedge clk) disable iff (!reset_n)
		(tick && prescale_sel == 3'h1 && timer_en) |=> !tick;
	endproperty
	a_div2: assert property (p_div2) else $error("divide by two ticked twice");

	property p_ovf; // R4
		@(posedge clk) disable iff (!reset_n)
		ovf_evt |=> flag_r[GCCT_NCH] && count_r == 16'h0000;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not flagged");

	property p_capture; // R5
		@(posedge clk) disable iff (!reset_n)
		cap_evt[1] |=> capture_value[31:16] == $past(count_r) && flag_r[1];
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong");

	property p_compare; // R6
		@(posedge clk) disable iff (!reset_n)
		(cmp_evt[0] && compare_action[1:0] == GCCT_ACT_SET) |=> chan_out[0];
	endproperty
	a_compare: assert property (p_compare) else $error("compare set action missed");

	property p_acc_mode; // R3
		@(posedge clk) disable iff (!reset_n)
		acc_enable |=> $stable(capture_value[GCCT_CNT_W*GCCT_ACC_CH +: GCCT_CNT_W]) && $stable(chan_out[GCCT_ACC_CH]);
	endproperty
	a_acc_mode: assert property (p_acc_mode) else $error("channel three active in accumulator mode");

	property p_acc; // R8
		@(posedge clk) disable iff (!reset_n)
		acc_inc |=> acc_r == $past(acc_r) + 16'h0001;
	endproperty
	a_acc: assert property (p_acc) else $error("accumulator did not count");

	property p_sticky; // R10
		@(posedge clk) disable iff (!reset_n)
		(flag_r[0] && !flag_clear[0]) |=> flag_r[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

	property p_mixed; // R7
		@(posedge clk) disable iff (!reset_n)
		(|ch_evt) |=> (flag_r[GCCT_NCH-1:0] & $past(ch_evt)) == $past(ch_evt);
	endproperty
	a_mixed: assert property (p_mixed) else $error("simultaneous events lost");

	c_capture: cover property (@(posedge clk) disable iff (!reset_n) cap_evt[1]);
	c_compare: cover property (@(posedge clk) disable iff (!reset_n) cmp_evt[0]);
	c_ovf: cover property (@(posedge clk) disable iff (!reset_n) ovf_evt);
	c_acc: cover property (@(posedge clk) disable iff (!reset_n) acc_inc && acc_gated);
endmodule // gcct_timer

// [bench/gcct_pin_model.sv]
/*
 Pin model for the timer: drives the capture pins as an outside source would.
 Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps
module gcct_pin_model (
	input wire logic clk,
	output logic [3:0] chan_in
);
	// ==========================================================
	// Pin levels, all low at start
	initial chan_in = 4'h0;
	// Set one pin level
	task automatic set_pin(input int ch, input logic v);
		chan_in[ch] = v;
	endtask
	// High for n cycles, then low for n cycles
	task automatic pulse(input int ch, input int n);
		chan_in[ch] = 1'h1;
		repeat (n) @(posedge clk);
		#1 chan_in[ch] = 1'h0;
		repeat (n) @(posedge clk);
		#1;
	endtask
endmodule // gcct_pin_model

// [bench/test_gcct_timer.sv]
/*
 Testbench for the capture/compare timer: prescale, capture, compare, accumulator, overflow.
 Assumes the pin model drives chan_in; inputs change 1 ns after the rising edge.
 */
`timescale 1ns/1ps
module test_gcct_timer;
	import gcct_pkg::*;
	logic clk = 0, reset_n = 0, timer_en = 0, acc_enable = 0, acc_gated = 0, acc_active_high = 1;
	logic [2:0] prescale_sel = 3'h0;
	logic [3:0] chan_is_compare = 4'h1;
	logic [7:0] capture_edge = 8'hC4;
	logic [7:0] compare_action = 8'h00;
	logic [63:0] compare_value = 64'h0;
	logic [5:0] flag_clear = 6'h00, flag_enable = 6'h00;
	logic [3:0] chan_in, chan_out;
	logic [15:0] count, acc_count, snap;
	logic [63:0] capture_value;
	logic [5:0] flags;
	logic irq;
	logic [1:0] acts [4] = '{GCCT_ACT_SET, GCCT_ACT_CLEAR, GCCT_ACT_TOGGLE, GCCT_ACT_NONE};
	logic exp_out [4] = '{1'h1, 1'h0, 1'h1, 1'h1};
	int mismatches = 0, checked = 0;
	always #5 clk = ~clk;
	gcct_timer u_gcct_timer (.clk, .reset_n, .timer_en, .prescale_sel, .chan_is_compare, .capture_edge,
		.compare_action, .compare_value, .acc_enable, .acc_gated, .acc_active_high, .chan_in, .flag_clear,
		.flag_enable, .count, .capture_value, .acc_count, .chan_out, .flags, .irq);
	gcct_pin_model u_gcct_pin_model (.clk, .chan_in);
	// ==========================================================
	// Helpers
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		#900000;
		mismatches++;
		give_verdict();
	end
	// ==========================================================
	// Main sequence
	initial begin
		step(8);
		reset_n = 1;
		step(2);
		chk("count at reset", count, 16'h0000);
		chk("flags at reset", 16'(flags), 16'h0000);
		timer_en = 1;
		for (int s = 0; s < 8; s++) begin
			prescale_sel = s[2:0];
			step(2);
			snap = count;
			step(256);
			chk("prescale steps", count - snap, 16'(256 >> s));
		end
		prescale_sel = 3'h0;
		// Capture with the counter frozen
		timer_en = 0;
		snap = count;
		u_gcct_pin_model.set_pin(1, 1'h1);
		step(5);
		chk("capture rise", capture_value[31:16], snap);
		chk("capture flag", 16'(flags[1]), 16'h0001);
		flag_clear = 6'h02;
		step(1);
		flag_clear = 6'h00;
		timer_en = 1;
		step(3);
		timer_en = 0;
		u_gcct_pin_model.set_pin(1, 1'h0);
		step(5);
		chk("fall ignored", capture_value[31:16], snap);
		chk("flag cleared", 16'(flags[1]), 16'h0000);
		// Falling edge select: rise ignored, fall captured
		capture_edge[3:2] = GCCT_EDGE_FALL;
		u_gcct_pin_model.set_pin(1, 1'h1);
		step(5);
		chk("rise ignored", capture_value[31:16], snap);
		timer_en = 1;
		step(3);
		timer_en = 0;
		snap = count;
		u_gcct_pin_model.set_pin(1, 1'h0);
		step(5);
		chk("capture fall", capture_value[31:16], snap);
		// Compare actions on channel 0, with no capture pin edges driven
		timer_en = 1;
		for (int a = 0; a < 4; a++) begin
			compare_action[1:0] = acts[a];
			compare_value[15:0] = count + 16'h0014;
			step(30);
			chk("compare out", 16'(chan_out[0]), 16'(exp_out[a]));
		end
		flag_enable = 6'h01;
		step(1);
		chk("irq on", 16'(irq), 16'h0001);
		flag_clear = 6'h01;
		step(1);
		flag_clear = 6'h00;
		step(1);
		chk("irq off", 16'(irq), 16'h0000);
		// Accumulator, event then gated
		acc_enable = 1;
		step(4);
		snap = acc_count;
		repeat (5) u_gcct_pin_model.pulse(3, 2);
		step(5);
		chk("acc events", acc_count - snap, 16'h0005);
		chk("ch3 capture held", capture_value[63:48], 16'h0000);
		chk("ch3 flag held", 16'(flags[3]), 16'h0000);
		// Event mode on falling edges
		acc_active_high = 0;
		snap = acc_count;
		repeat (3) u_gcct_pin_model.pulse(3, 2);
		step(5);
		chk("acc falls", acc_count - snap, 16'h0003);
		acc_active_high = 1;
		acc_gated = 1;
		step(5);
		snap = acc_count;
		u_gcct_pin_model.pulse(3, 10);
		step(5);
		chk("acc gated", acc_count - snap, 16'h000A);
		// Counter wrap, then accumulator wrap with its pin held active
		u_gcct_pin_model.set_pin(3, 1'h1);
		flag_clear = 6'h3F;
		step(1);
		flag_clear = 6'h00;
		for (int i = 0; i < 70000 && count !== 16'hFFFF; i++) step(1);
		chk("no early wrap", 16'(flags[4]), 16'h0000);
		step(2);
		chk("wrap flag", 16'(flags[4]), 16'h0001);
		for (int i = 0; i < 70000 && acc_count !== 16'hFFFF; i++) step(1);
		chk("no early acc wrap", 16'(flags[5]), 16'h0000);
		step(2);
		chk("acc wrap flag", 16'(flags[5]), 16'h0001);
		give_verdict();
	end
endmodule // test_gcct_timer
